/* logic/ivm_pkg.sv */
// constants for the reset and interrupt vector address map
package ivm_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int NUM_SRC = 34;
  localparam int IDX_W = 6;
  localparam int CTRL_W = 8;

  // --------------------------------------------------------------------
  // processor control register
  // --------------------------------------------------------------------
  localparam int VSEL_BIT = 1;
  localparam logic [CTRL_W-1:0] PCR_RESET = 8'h00;

  // --------------------------------------------------------------------
  // addresses, all in program words
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR = 17'h1F000;
  localparam logic [ADDR_W-1:0] VEC_STEP = 17'h00002;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;

  // --------------------------------------------------------------------
  // vector numbering: source index i is vector number i + 2
  // --------------------------------------------------------------------
  localparam logic [IDX_W-1:0] RESET_VEC_NUM = 6'h01;
  localparam logic [IDX_W-1:0] SRC_VEC_BIAS = 6'h02;
  localparam logic [IDX_W-1:0] FIRST_T3_IDX = 6'h1E;

  // first source index and table offset of each group
  localparam logic [IDX_W-1:0] IDX_EXT0 = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PCHG0 = 6'h03;
  localparam logic [IDX_W-1:0] IDX_WDT = 6'h07;
  localparam logic [IDX_W-1:0] IDX_T2A = 6'h08;
  localparam logic [IDX_W-1:0] IDX_T1CAP = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_T0A = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_SPI = 6'h12;
  localparam logic [IDX_W-1:0] IDX_SER0RX = 6'h13;
  localparam logic [IDX_W-1:0] IDX_TWI = 6'h19;
  localparam logic [IDX_W-1:0] IDX_PSR = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_SER1RX = 6'h1B;
  localparam logic [IDX_W-1:0] IDX_T3CAP = 6'h1E;
  localparam logic [ADDR_W-1:0] OFS_EXT0 = 17'h00002;
  localparam logic [ADDR_W-1:0] OFS_PCHG0 = 17'h00008;
  localparam logic [ADDR_W-1:0] OFS_WDT = 17'h00010;
  localparam logic [ADDR_W-1:0] OFS_T2A = 17'h00012;
  localparam logic [ADDR_W-1:0] OFS_T1CAP = 17'h00018;
  localparam logic [ADDR_W-1:0] OFS_T0A = 17'h00020;
  localparam logic [ADDR_W-1:0] OFS_SPI = 17'h00026;
  localparam logic [ADDR_W-1:0] OFS_SER0RX = 17'h00028;
  localparam logic [ADDR_W-1:0] OFS_TWI = 17'h00034;
  localparam logic [ADDR_W-1:0] OFS_PSR = 17'h00036;
  localparam logic [ADDR_W-1:0] OFS_SER1RX = 17'h00038;
  localparam logic [ADDR_W-1:0] OFS_T3CAP = 17'h0003E;

  // --------------------------------------------------------------------
  // timing: cycles the fuse synchroniser needs to fill after reset
  // --------------------------------------------------------------------
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

endpackage : ivm_pkg

/* logic/ivm_prio.sv */
// lowest-index-first selection among pending interrupt sources
`timescale 1ns/100ps
`default_nettype none

module ivm_prio (
  input wire logic [ivm_pkg::NUM_SRC-1:0] req_i,
  output logic any_o,
  output logic [ivm_pkg::IDX_W-1:0] idx_o,
  output logic [ivm_pkg::NUM_SRC-1:0] onehot_o
);

  // lower_seen[i] is high when any source below i is pending
  logic [ivm_pkg::NUM_SRC:0] lower_seen;

  assign lower_seen[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < ivm_pkg::NUM_SRC; g++) begin : g_chain
      assign lower_seen[g+1] = lower_seen[g] | req_i[g];
      assign onehot_o[g] = req_i[g] & ~lower_seen[g]; // RQ18
    end
  endgenerate

  assign any_o = lower_seen[ivm_pkg::NUM_SRC];

  always_comb begin
    idx_o = '0;
    for (int i = 0; i < ivm_pkg::NUM_SRC; i++) begin
      if (onehot_o[i]) begin
        idx_o = ivm_pkg::IDX_W'(i);
      end
    end
  end

endmodule : ivm_prio

`default_nettype wire

/* logic/ivm_sync.sv */
// two-flop synchroniser for a level coming from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module ivm_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic stage1;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : ivm_sync

`default_nettype wire

/* logic/ivm_vector_map.sv */
// reset and interrupt vector address generator for the processor core
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// (RQ1) every reset cause uses vector 1, address zero unless the boot fuse is programmed
// (RQ2) external requests 0..2 at 0x02, 0x04, 0x06
// (RQ3) pin-change groups 0..3 at 0x08 to 0x0E
// (RQ4) watchdog time-out vectors to offset 0x10
// (RQ5) timer 2 match A, B, overflow at 0x12-0x16
// (RQ6) timer 1 capture, A, B, overflow at 0x18-0x1E
// (RQ7) timer 0 match A, B, overflow at 0x20-0x24
// (RQ8) SPI transfer complete vectors to offset 0x26
// (RQ9) serial port 0 events at 0x28, 0x2A, 0x2C
// (RQ10) two-wire at 0x34, program store ready at 0x36
// (RQ11) serial port 1 events at 0x38, 0x3A, 0x3C
// (RQ12) timer 3 events at 0x3E-0x44 when present
// (RQ13) programmed boot fuse starts at boot reset address
// (RQ14) select bit set: vectors offset from boot start
// (RQ15) reset and vector base chosen by fuse, bit
// (RQ16) fuse one is unprogrammed, zero is programmed
// (RQ17) vector select is control register bit 1
// (RQ18) lowest pending vector number is served first
module ivm_vector_map #(
  parameter bit HAS_TIMER3 = 1'b1
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic BOOT_RESET_FUSE_I,
  input wire logic PCR_WE_I,
  input wire logic [ivm_pkg::CTRL_W-1:0] PCR_WDATA_I,
  input wire logic CORE_INT_EN_I,
  input wire logic [ivm_pkg::NUM_SRC-1:0] IRQ_REQ_I,
  output logic [ivm_pkg::CTRL_W-1:0] PCR_RDATA_O,
  output logic VECTOR_TABLE_SELECT_O,
  output logic BOOT_FUSE_PROGRAMMED_O,
  output logic VEC_VALID_O,
  output logic VEC_IS_RESET_O,
  output logic [ivm_pkg::ADDR_W-1:0] VEC_ADDR_O,
  output logic [ivm_pkg::IDX_W-1:0] VEC_NUM_O,
  output logic [ivm_pkg::NUM_SRC-1:0] IRQ_ACK_O
);

  // --------------------------------------------------------------------
  // types and state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_RESET_FETCH,
    ST_IDLE,
    ST_RECOVER
  } ivm_state_type;

  ivm_state_type state;
  ivm_state_type next_state;
  logic [1:0] settle_cnt;
  logic [ivm_pkg::CTRL_W-1:0] pcr;
  logic fuse_sync;
  logic fuse_latched;

  // table offset of a source index: vector n sits at 2 * (n - 1)
  function automatic logic [ivm_pkg::ADDR_W-1:0] vec_offset(
    input logic [ivm_pkg::IDX_W-1:0] idx
  );
    logic [ivm_pkg::ADDR_W-1:0] step_count;
    step_count = ivm_pkg::ADDR_W'(idx) + ivm_pkg::ADDR_W'(1); // RQ8 RQ9 RQ10 RQ11
    vec_offset = ivm_pkg::ADDR_W'(step_count << 1); // RQ3 RQ4 RQ5 RQ6 RQ7
  endfunction : vec_offset

  // --------------------------------------------------------------------
  // boot fuse: synchronised, then caught once after reset release
  // --------------------------------------------------------------------
  ivm_sync #(
    .RESET_VAL(ivm_pkg::FUSE_UNPROGRAMMED)
  ) u_fuse_sync (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .async_i(BOOT_RESET_FUSE_I),
    .sync_o(fuse_sync)
  );

  // the fuse is sampled only at the reset fetch, so a fuse edge mid-run
  // cannot change BOOT_FUSE_PROGRAMMED_O under an already running program
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      fuse_latched <= ivm_pkg::FUSE_UNPROGRAMMED;
    end else if (state == ST_RESET_FETCH) begin
      fuse_latched <= fuse_sync;
    end
  end

  wire fuse_now_programmed = (fuse_sync == ivm_pkg::FUSE_PROGRAMMED); // RQ16
  assign BOOT_FUSE_PROGRAMMED_O = (fuse_latched == ivm_pkg::FUSE_PROGRAMMED);

  // --------------------------------------------------------------------
  // processor control register
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      pcr <= ivm_pkg::PCR_RESET;
    end else if (PCR_WE_I) begin
      pcr <= PCR_WDATA_I;
    end
  end

  assign PCR_RDATA_O = pcr;
  assign VECTOR_TABLE_SELECT_O = pcr[ivm_pkg::VSEL_BIT]; // RQ17

  // --------------------------------------------------------------------
  // source selection and address forming
  // --------------------------------------------------------------------
  wire [ivm_pkg::NUM_SRC-1:0] t3_mask;
  wire [ivm_pkg::NUM_SRC-1:0] live_req;
  wire any_req;
  wire [ivm_pkg::IDX_W-1:0] win_idx;
  wire [ivm_pkg::NUM_SRC-1:0] win_onehot;

  // sources from the timer 3 group upward only exist on the larger variant
  genvar g;
  generate
    for (g = 0; g < ivm_pkg::NUM_SRC; g++) begin : g_mask
      assign t3_mask[g] = HAS_TIMER3 || (g < int'(ivm_pkg::FIRST_T3_IDX)); // RQ12
    end
  endgenerate

  assign live_req = IRQ_REQ_I & t3_mask;

  ivm_prio u_prio (
    .req_i(live_req),
    .any_o(any_req),
    .idx_o(win_idx),
    .onehot_o(win_onehot)
  );

  wire [ivm_pkg::ADDR_W-1:0] reset_addr = fuse_now_programmed ?
    ivm_pkg::BOOT_RESET_ADDR : ivm_pkg::APP_RESET_ADDR; // RQ1 RQ13 RQ15
  wire [ivm_pkg::ADDR_W-1:0] vec_base = VECTOR_TABLE_SELECT_O ?
    ivm_pkg::BOOT_RESET_ADDR : ivm_pkg::APP_RESET_ADDR; // RQ14 RQ15
  wire [ivm_pkg::ADDR_W-1:0] irq_addr = vec_base + vec_offset(win_idx); // RQ2
  wire accept = (state == ST_IDLE) && CORE_INT_EN_I && any_req;

  // --------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_SETTLE: begin
        if (settle_cnt == ivm_pkg::SETTLE_CYCLES) begin
          next_state = ST_RESET_FETCH;
        end
      end
      ST_RESET_FETCH: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_RECOVER;
        end
      end
      // one spare cycle lets the acknowledged source drop its request,
      // otherwise the same vector would be served twice
      ST_RECOVER: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state <= ST_SETTLE;
      settle_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (state == ST_SETTLE) begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // vector output to the core
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      VEC_VALID_O <= 1'b0;
      VEC_IS_RESET_O <= 1'b0;
      VEC_ADDR_O <= ivm_pkg::APP_RESET_ADDR;
      VEC_NUM_O <= '0;
      IRQ_ACK_O <= '0;
    end else begin
      VEC_VALID_O <= 1'b0;
      VEC_IS_RESET_O <= 1'b0;
      IRQ_ACK_O <= '0;
      if (state == ST_RESET_FETCH) begin
        VEC_VALID_O <= 1'b1;
        VEC_IS_RESET_O <= 1'b1;
        VEC_ADDR_O <= reset_addr; // RQ1
        VEC_NUM_O <= ivm_pkg::RESET_VEC_NUM;
      end else if (accept) begin
        VEC_VALID_O <= 1'b1;
        VEC_ADDR_O <= irq_addr; // RQ14
        VEC_NUM_O <= win_idx + ivm_pkg::SRC_VEC_BIAS;
        IRQ_ACK_O <= win_onehot; // RQ18
      end
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  logic [ivm_pkg::ADDR_W-1:0] chk_base;
  logic [ivm_pkg::IDX_W-1:0] chk_idx;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      chk_base <= '0;
      chk_idx <= '0;
    end else if (accept) begin
      chk_base <= vec_base;
      chk_idx <= win_idx;
    end
  end

  wire [ivm_pkg::ADDR_W-1:0] chk_rel = VEC_ADDR_O - chk_base;
  wire irq_out = VEC_VALID_O && !VEC_IS_RESET_O;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence seq_reset_release;
    $fell(SRST_I);
  endsequence

  sequence seq_reset_fetch;
    VEC_VALID_O && VEC_IS_RESET_O;
  endsequence

  AST_RESET_APP: assert property ( // RQ1
    seq_reset_fetch and !BOOT_FUSE_PROGRAMMED_O |-> VEC_ADDR_O == ivm_pkg::APP_RESET_ADDR
  ) else $error("reset fetch with fuse unprogrammed not at zero");

  AST_RESET_BOOT: assert property ( // RQ13
    seq_reset_fetch and BOOT_FUSE_PROGRAMMED_O |-> VEC_ADDR_O == ivm_pkg::BOOT_RESET_ADDR
  ) else $error("reset fetch with fuse programmed not at boot address");

  AST_RESET_TIMING: assert property ( // RQ15
    @(posedge CORE_CLK_I) seq_reset_release |-> !VEC_VALID_O [*4] ##1 seq_reset_fetch
  ) else $error("reset fetch not issued four cycles after release");

  AST_RESET_NUM: assert property ( // RQ1
    seq_reset_fetch |-> VEC_NUM_O == ivm_pkg::RESET_VEC_NUM && IRQ_ACK_O == '0
  ) else $error("reset fetch carries wrong vector number");

  AST_VSEL_WRITE: assert property ( // RQ17
    PCR_WE_I |=> VECTOR_TABLE_SELECT_O == $past(PCR_WDATA_I[ivm_pkg::VSEL_BIT])
  ) else $error("vector select does not follow control write");

  AST_BASE_BOOT: assert property ( // RQ14
    irq_out && chk_base == ivm_pkg::BOOT_RESET_ADDR |->
      VEC_ADDR_O == ivm_pkg::BOOT_RESET_ADDR + vec_offset(chk_idx)
  ) else $error("moved table address wrong");

  AST_BASE_APP: assert property ( // RQ15
    accept && !VECTOR_TABLE_SELECT_O |=> VEC_ADDR_O == vec_offset($past(win_idx))
  ) else $error("application table address wrong");

  AST_NUM_OFFSET: assert property ( // RQ2
    irq_out |-> chk_rel == ivm_pkg::ADDR_W'({VEC_NUM_O, 1'b0}) - ivm_pkg::VEC_STEP
  ) else $error("vector number and address disagree");

  AST_LOWEST_FIRST: assert property ( // RQ18
    accept |=> $onehot(IRQ_ACK_O) && ((IRQ_ACK_O - 1'b1) & $past(live_req)) == '0
  ) else $error("served source is not the lowest pending");

  AST_ONE_PULSE: assert property ( // RQ18
    irq_out |=> !VEC_VALID_O && (state == ST_IDLE)
  ) else $error("vector strobe longer than one cycle");

  AST_NO_T3: assert property ( // RQ12
    !HAS_TIMER3 |-> IRQ_ACK_O[ivm_pkg::NUM_SRC-1:ivm_pkg::FIRST_T3_IDX] == '0
  ) else $error("timer 3 served on variant without it");

  AST_OFS_PCHG: assert property ( // RQ3
    irq_out && chk_idx == ivm_pkg::IDX_PCHG0 |-> chk_rel == ivm_pkg::OFS_PCHG0
  ) else $error("pin-change group 0 offset wrong");

  AST_OFS_WDT: assert property ( // RQ4
    irq_out && chk_idx == ivm_pkg::IDX_WDT |-> chk_rel == ivm_pkg::OFS_WDT
  ) else $error("watchdog offset wrong");

  AST_OFS_T2: assert property ( // RQ5
    irq_out && chk_idx == ivm_pkg::IDX_T2A |-> chk_rel == ivm_pkg::OFS_T2A
  ) else $error("timer 2 match A offset wrong");

  AST_OFS_T1: assert property ( // RQ6
    irq_out && chk_idx == ivm_pkg::IDX_T1CAP |-> chk_rel == ivm_pkg::OFS_T1CAP
  ) else $error("timer 1 capture offset wrong");

  AST_OFS_T0: assert property ( // RQ7
    irq_out && chk_idx == ivm_pkg::IDX_T0A |-> chk_rel == ivm_pkg::OFS_T0A
  ) else $error("timer 0 match A offset wrong");

  AST_OFS_SPI: assert property ( // RQ8
    irq_out && chk_idx == ivm_pkg::IDX_SPI |-> chk_rel == ivm_pkg::OFS_SPI
  ) else $error("SPI offset wrong");

  AST_OFS_SER0: assert property ( // RQ9
    irq_out && chk_idx == ivm_pkg::IDX_SER0RX |-> chk_rel == ivm_pkg::OFS_SER0RX
  ) else $error("serial port 0 receive offset wrong");

  AST_OFS_TWI: assert property ( // RQ10
    irq_out && chk_idx == ivm_pkg::IDX_TWI |-> chk_rel == ivm_pkg::OFS_TWI
  ) else $error("two-wire offset wrong");

  AST_OFS_PSR: assert property ( // RQ10
    irq_out && chk_idx == ivm_pkg::IDX_PSR |-> chk_rel == ivm_pkg::OFS_PSR
  ) else $error("program store ready offset wrong");

  AST_OFS_SER1: assert property ( // RQ11
    irq_out && chk_idx == ivm_pkg::IDX_SER1RX |-> chk_rel == ivm_pkg::OFS_SER1RX
  ) else $error("serial port 1 receive offset wrong");

  AST_OFS_T3: assert property ( // RQ12
    irq_out && chk_idx == ivm_pkg::IDX_T3CAP |-> chk_rel == ivm_pkg::OFS_T3CAP
  ) else $error("timer 3 capture offset wrong");

  AST_OFS_EXT0: assert property ( // RQ2
    irq_out && chk_idx == ivm_pkg::IDX_EXT0 |-> chk_rel == ivm_pkg::OFS_EXT0
  ) else $error("external request 0 offset wrong");

endmodule : ivm_vector_map

`default_nettype wire

/* verification/ivm_core_model.sv */
// processor core side: holds pending sources and the global interrupt enable
`timescale 1ns/100ps
`default_nettype none

module ivm_core_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic [ivm_pkg::NUM_SRC-1:0] set_i,
  input wire logic [ivm_pkg::NUM_SRC-1:0] ack_i,
  input wire logic valid_i,
  output logic [ivm_pkg::NUM_SRC-1:0] req_o,
  output logic int_en_o
);
  // ------------------------------------------------------------------
  // pending sources
  // ------------------------------------------------------------------
  logic [1:0] gap;
  // slow core: enable drops for a while after each vector it takes
  assign int_en_o = (gap == 2'h0);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_o <= '0;
      gap <= 2'h0;
    end else begin
      // a served source drops on the edge after its acknowledge
      req_o <= (req_o & ~ack_i) | set_i;
      if (valid_i && slow_i) begin
        gap <= 2'h3;
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end
    end
  end
endmodule : ivm_core_model

`default_nettype wire

/* verification/ivm_vector_map_tb_top.sv */
// self-checking bench for the vector address generator
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH at %0t: %s", $time, msg); end end

module ivm_vector_map_tb_top;
  typedef struct {
    logic [16:0] addr;
    logic [5:0] num;
    logic rst;
    logic [33:0] ack;
  } ivm_exp_type;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fuse = 1'b1;
  logic we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic slow = 1'b0;
  logic [33:0] set_src = '0;
  wire logic en;
  wire logic [33:0] req;
  logic [7:0] rdata;
  logic vsel, fprog, valid, is_rst;
  logic [16:0] vaddr;
  logic [5:0] vnum;
  logic [33:0] ack;
  logic valid_n3;
  logic [33:0] ack_n3;
  ivm_exp_type q[$];
  int n_errors = 0;
  int n_checks = 0;
  integer seed = 64836;

  initial begin
    forever #12.5 clk = ~clk;
  end

  ivm_vector_map u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .BOOT_RESET_FUSE_I(fuse),
    .PCR_WE_I(we), .PCR_WDATA_I(wdata), .CORE_INT_EN_I(en), .IRQ_REQ_I(req),
    .PCR_RDATA_O(rdata), .VECTOR_TABLE_SELECT_O(vsel), .BOOT_FUSE_PROGRAMMED_O(fprog),
    .VEC_VALID_O(valid), .VEC_IS_RESET_O(is_rst), .VEC_ADDR_O(vaddr), .VEC_NUM_O(vnum),
    .IRQ_ACK_O(ack));

  ivm_core_model u_core (.clk_i(clk), .srst_i(srst), .slow_i(slow), .set_i(set_src),
    .ack_i(ack), .valid_i(valid), .req_o(req), .int_en_o(en));

  // variant without timer 3 runs in step on the same core, ignoring bits 30..33
  ivm_vector_map #(.HAS_TIMER3(1'b0)) u_dut_no_t3 (.CORE_CLK_I(clk), .SRST_I(srst),
    .BOOT_RESET_FUSE_I(fuse), .PCR_WE_I(we), .PCR_WDATA_I(wdata), .CORE_INT_EN_I(en),
    .IRQ_REQ_I(req), .PCR_RDATA_O(), .VECTOR_TABLE_SELECT_O(), .BOOT_FUSE_PROGRAMMED_O(),
    .VEC_VALID_O(valid_n3), .VEC_IS_RESET_O(), .VEC_ADDR_O(), .VEC_NUM_O(),
    .IRQ_ACK_O(ack_n3));

  // ------------------------------------------------------------------
  // monitor: every strobe takes the oldest expectation
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    ivm_exp_type e;
    if (valid === 1'b1) begin
      if (q.size() == 0) begin
        `CHK(1'b1, 1'b0, "strobe with nothing expected")
      end else begin
        e = q.pop_front();
        `CHK(vaddr, e.addr, "vector address")
        `CHK(vnum, e.num, "vector number")
        `CHK(is_rst, e.rst, "reset marker")
        `CHK(ack, e.ack, "acknowledge")
        `CHK(valid_n3, e.ack[33:30] == 4'h0, "variant strobe")
        `CHK(ack_n3, (e.ack[33:30] == 4'h0) ? e.ack : 34'h0, "variant acknowledge")
      end
    end else if (!srst) begin
      `CHK(valid_n3, 1'b0, "variant strobe alone")
    end
  end

  // ------------------------------------------------------------------
  // driver tasks
  // ------------------------------------------------------------------
  task automatic push_src(input int i, input logic sel);
    ivm_exp_type e;
    e.addr = (sel ? ivm_pkg::BOOT_RESET_ADDR : 17'h00000) + 17'(2 * (i + 1));
    e.num = 6'(i + 2);
    e.rst = 1'b0;
    e.ack = 34'h000000001 << i;
    q.push_back(e);
  endtask : push_src

  task automatic raise(input logic [33:0] m);
    @(posedge clk);
    set_src <= m;
    @(posedge clk);
    set_src <= '0;
  endtask : raise

  task automatic wait_idle();
    int k;
    k = 0;
    while (q.size() != 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    `CHK(q.size(), 0, "expected strobe never came")
    repeat (3) @(posedge clk);
  endtask : wait_idle

  task automatic pcr_write(input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
    `CHK(rdata, d, "control register read back")
    `CHK(vsel, d[1], "vector select bit")
  endtask : pcr_write

  task automatic do_reset(input logic f);
    ivm_exp_type e;
    @(posedge clk);
    srst <= 1'b1;
    fuse <= f;
    repeat (12) @(posedge clk);
    @(negedge clk);
    `CHK(rdata, ivm_pkg::PCR_RESET, "control register reset value")
    `CHK(vsel, 1'b0, "select clear after reset")
    // fuse one leaves the reset in the application area
    e.addr = f ? 17'h00000 : ivm_pkg::BOOT_RESET_ADDR;
    e.num = 6'h01;
    e.rst = 1'b1;
    e.ack = '0;
    q.push_back(e);
    @(posedge clk);
    srst <= 1'b0;
    wait_idle();
    `CHK(fprog, ~f, "fuse state seen at reset")
  endtask : do_reset

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [33:0] m;
    do_reset(1'b1);
    pcr_write(8'hFD);
    for (int s = 0; s < 2; s++) begin
      pcr_write(s ? 8'h02 : 8'h00);
      for (int i = 0; i < 34; i++) begin
        push_src(i, s[0]);
        raise(34'h000000001 << i);
        wait_idle();
      end
    end
    // several sources at once, fast and slow core, lowest number first
    for (int r = 0; r < 8; r++) begin
      slow <= r[0];
      m = 34'({$random(seed), $random(seed)});
      m[r] = 1'b1;
      for (int i = 0; i < 34; i++) begin
        if (m[i]) begin
          push_src(i, 1'b1);
        end
      end
      raise(m);
      wait_idle();
    end
    slow <= 1'b0;
    do_reset(1'b0);
    push_src(0, 1'b0);
    raise(34'h000000001);
    wait_idle();
    pcr_write(8'h02);
    push_src(26, 1'b1);
    raise(34'h000000001 << 26);
    wait_idle();
    complete_run();
  end

  initial begin
    #400us;
    n_errors++;
    complete_run();
  end
endmodule : ivm_vector_map_tb_top

`default_nettype wire
